// ==== logic/alcs_device.sv ====
/*
  device end: configuration word, flag word, flag pins and the logic the
  configuration steers (rate ticks, parity, loopback, word filter, label mode).
  assumes fifo levels, words and pulses come from logic on clk.
*/
`timescale 1ns/1ps
module alcs_device (
  input wire logic clk,
  input wire logic rst,
  alcs_bus_if.dev bus,
  input wire logic [5:0] rx_one_count,
  input wire logic [5:0] rx_two_count,
  input wire logic [5:0] tx_count,
  input wire logic tx_load_pulse,
  input wire logic [1:0] rx_read_pulse,
  input wire logic [30:0] tx_word_low,
  input wire logic tx_data_bit32,
  input wire logic tx_serial,
  input wire logic [1:0] rx_line_in,
  input wire logic [1:0] rx_word_done,
  input wire logic [1:0] rx_bit9,
  input wire logic [1:0] rx_bit10,
  input wire logic [1:0] rx_label_hit,
  output logic tx_label_write,
  output logic tx_fifo_write,
  output logic [1:0] rx_label_read,
  output logic [1:0] rx_fifo_read,
  output logic [2:0] rate_tick,
  output logic tx_bit32_out,
  output logic [1:0] rx_logic_in,
  output logic [1:0] rx_fifo_load,
  output logic [15:0] config_word,
  output logic word_bit_order
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [15:0] data_s1_reg;
  logic [15:0] data_s2_reg;
  logic [2:0] ctl_s1_reg;
  logic [2:0] ctl_s2_reg;
  logic cfg_stb_prev_reg;
  logic [15:0] cfg_reg;
  logic [8:0] flag_reg;
  wire [2:0] ctl_pins = {bus.half_select, bus.register_read_strobe_n,
    bus.config_word_strobe_n};
  wire cfg_stb_s = ctl_s2_reg[0];
  wire rd_stb_s = ctl_s2_reg[1];
  wire half_sel_s = ctl_s2_reg[2];

  always_ff @(posedge clk) begin
    if (rst) begin
      data_s1_reg <= 16'h0000;
      data_s2_reg <= 16'h0000;
      ctl_s1_reg <= 3'h3;
      ctl_s2_reg <= 3'h3;
    end else begin
      data_s1_reg <= bus.parallel_data_lines;
      data_s2_reg <= data_s1_reg;
      ctl_s1_reg <= ctl_pins;
      ctl_s2_reg <= ctl_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration word
  wire cfg_latch = cfg_stb_s & ~cfg_stb_prev_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_stb_prev_reg <= 1'b1;
      cfg_reg <= alcs_pkg::CFG_RESET;
    end else begin
      cfg_stb_prev_reg <= cfg_stb_s;
      if (cfg_latch) begin
        cfg_reg <= data_s2_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flag word and pins
  logic [8:0] flag_next;
  always_comb begin
    flag_next = 9'h000;
    flag_next[alcs_pkg::FB_RX1_DATA] = rx_one_count != alcs_pkg::LEVEL_EMPTY;
    flag_next[alcs_pkg::FB_RX1_HALF] = rx_one_count >= alcs_pkg::LEVEL_HALF;
    flag_next[alcs_pkg::FB_RX1_FULL] = rx_one_count >= alcs_pkg::LEVEL_FULL;
    flag_next[alcs_pkg::FB_RX2_DATA] = rx_two_count != alcs_pkg::LEVEL_EMPTY;
    flag_next[alcs_pkg::FB_RX2_HALF] = rx_two_count >= alcs_pkg::LEVEL_HALF;
    flag_next[alcs_pkg::FB_RX2_FULL] = rx_two_count >= alcs_pkg::LEVEL_FULL;
    flag_next[alcs_pkg::FB_TX_EMPTY] = tx_count == alcs_pkg::LEVEL_EMPTY;
    flag_next[alcs_pkg::FB_TX_FULL] = tx_count >= alcs_pkg::LEVEL_FULL;
    flag_next[alcs_pkg::FB_TX_HALF] = tx_count >= alcs_pkg::LEVEL_HALF;
  end

  wire [15:0] rd_word = half_sel_s ? cfg_reg : {7'h00, flag_reg};

  always_ff @(posedge clk) begin
    if (rst) begin
      flag_reg <= alcs_pkg::FLAG_RESET;
      bus.d2h_data <= 16'h0000;
      bus.d2h_oe <= 1'b0;
      bus.rx_one_ready_pin_n <= 1'b1;
      bus.rx_one_half_pin_n <= 1'b1;
      bus.rx_one_full_pin_n <= 1'b1;
      bus.rx_two_ready_pin_n <= 1'b1;
      bus.rx_two_half_pin_n <= 1'b1;
      bus.rx_two_full_pin_n <= 1'b1;
      bus.tx_full_pin_n <= 1'b1;
      bus.tx_half_pin_n <= 1'b1;
    end else begin
      flag_reg <= flag_next;
      bus.d2h_data <= rd_stb_s ? 16'h0000 : rd_word;
      bus.d2h_oe <= ~rd_stb_s;
      bus.rx_one_ready_pin_n <= ~flag_next[alcs_pkg::FB_RX1_DATA];
      bus.rx_one_half_pin_n <= ~flag_next[alcs_pkg::FB_RX1_HALF];
      bus.rx_one_full_pin_n <= ~flag_next[alcs_pkg::FB_RX1_FULL];
      bus.rx_two_ready_pin_n <= ~flag_next[alcs_pkg::FB_RX2_DATA];
      bus.rx_two_half_pin_n <= ~flag_next[alcs_pkg::FB_RX2_HALF];
      bus.rx_two_full_pin_n <= ~flag_next[alcs_pkg::FB_RX2_FULL];
      bus.tx_full_pin_n <= ~flag_next[alcs_pkg::FB_TX_FULL];
      bus.tx_half_pin_n <= ~flag_next[alcs_pkg::FB_TX_HALF];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rate dividers: 0 receiver one, 1 receiver two, 2 transmitter
  wire [2:0] rate_slow = {cfg_reg[alcs_pkg::CB_TX_RATE], cfg_reg[alcs_pkg::CB_RX2_RATE],
    cfg_reg[alcs_pkg::CB_RX1_RATE]};

  for (genvar g = 0; g < 3; g++) begin : g_div
    logic [6:0] div_reg;
    wire [6:0] div_last = rate_slow[g] ? alcs_pkg::DIV_SLOW_LAST : alcs_pkg::DIV_FAST_LAST;
    wire div_wrap = div_reg >= div_last;
    always_ff @(posedge clk) begin
      if (rst) begin
        div_reg <= 7'h00;
        rate_tick[g] <= 1'b0;
      end else begin
        div_reg <= div_wrap ? 7'h00 : div_reg + 7'h01;
        rate_tick[g] <= div_wrap;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver paths: loopback, word filter, label read steering
  wire [1:0] label_en = {cfg_reg[alcs_pkg::CB_RX2_LABEL_EN], cfg_reg[alcs_pkg::CB_RX1_LABEL_EN]};
  wire [1:0] sdi_en = {cfg_reg[alcs_pkg::CB_RX2_SDI_EN], cfg_reg[alcs_pkg::CB_RX1_SDI_EN]};
  wire [1:0] exp_b9 = {cfg_reg[alcs_pkg::CB_RX2_B9], cfg_reg[alcs_pkg::CB_RX1_B9]};
  wire [1:0] exp_b10 = {cfg_reg[alcs_pkg::CB_RX2_B10], cfg_reg[alcs_pkg::CB_RX1_B10]};
  wire label_mode = cfg_reg[alcs_pkg::CB_LABEL_MEM];
  wire loop_n = cfg_reg[alcs_pkg::CB_LOOP_N];

  for (genvar g = 0; g < 2; g++) begin : g_rx
    wire sdi_ok = ~sdi_en[g] | (rx_bit9[g] == exp_b9[g] && rx_bit10[g] == exp_b10[g]);
    wire label_ok = ~label_en[g] | rx_label_hit[g];
    always_ff @(posedge clk) begin
      if (rst) begin
        rx_fifo_load[g] <= 1'b0;
        rx_logic_in[g] <= 1'b0;
        rx_label_read[g] <= 1'b0;
        rx_fifo_read[g] <= 1'b0;
      end else begin
        rx_fifo_load[g] <= rx_word_done[g] & sdi_ok & label_ok;
        rx_logic_in[g] <= loop_n ? rx_line_in[g] : tx_serial;
        rx_label_read[g] <= rx_read_pulse[g] & label_mode;
        rx_fifo_read[g] <= rx_read_pulse[g] & ~label_mode;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmitter bit 32, load steering, configuration fields
  wire odd_bit = ~^tx_word_low;
  wire par_bit = cfg_reg[alcs_pkg::CB_PAR_POL] ? ~odd_bit : odd_bit;

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_bit32_out <= 1'b0;
      tx_label_write <= 1'b0;
      tx_fifo_write <= 1'b0;
      config_word <= alcs_pkg::CFG_RESET;
      word_bit_order <= alcs_pkg::CFG_RESET[alcs_pkg::CB_ORDER];
    end else begin
      tx_bit32_out <= cfg_reg[alcs_pkg::CB_PAR_EN] ? par_bit : tx_data_bit32;
      tx_label_write <= tx_load_pulse & label_mode;
      tx_fifo_write <= tx_load_pulse & ~label_mode;
      config_word <= cfg_reg;
      word_bit_order <= cfg_reg[alcs_pkg::CB_ORDER];
    end
  end
endmodule // alcs_device

// ==== inc/alcs_pkg.sv ====
/*
  constants for the avionics link configuration and flag word logic.
  assumes a 125 MHz clock shared by both ends.
*/
package alcs_pkg;
  localparam int CFG_W = 16;
  localparam int FLAG_W = 9;
  localparam int CNT_W = 6;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  // configuration word fields
  localparam int CB_RX1_RATE = 0;
  localparam int CB_LABEL_MEM = 1;
  localparam int CB_RX1_LABEL_EN = 2;
  localparam int CB_RX2_LABEL_EN = 3;
  localparam int CB_PAR_EN = 4;
  localparam int CB_LOOP_N = 5;
  localparam int CB_RX1_SDI_EN = 6;
  localparam int CB_RX1_B9 = 7;
  localparam int CB_RX1_B10 = 8;
  localparam int CB_RX2_SDI_EN = 9;
  localparam int CB_RX2_B9 = 10;
  localparam int CB_RX2_B10 = 11;
  localparam int CB_PAR_POL = 12;
  localparam int CB_TX_RATE = 13;
  localparam int CB_RX2_RATE = 14;
  localparam int CB_ORDER = 15;
  // flag word fields
  localparam int FB_RX1_DATA = 0;
  localparam int FB_RX1_HALF = 1;
  localparam int FB_RX1_FULL = 2;
  localparam int FB_RX2_DATA = 3;
  localparam int FB_RX2_HALF = 4;
  localparam int FB_RX2_FULL = 5;
  localparam int FB_TX_EMPTY = 6;
  localparam int FB_TX_FULL = 7;
  localparam int FB_TX_HALF = 8;
  localparam logic [5:0] LEVEL_EMPTY = 6'h00;
  localparam logic [5:0] LEVEL_HALF = 6'h10;
  localparam logic [5:0] LEVEL_FULL = 6'h20;
  localparam logic [8:0] FLAG_RESET = 9'h040;
  // rate dividers
  localparam int DIV_W = 7;
  localparam logic [6:0] DIV_FAST_LAST = 7'h09;
  localparam logic [6:0] DIV_SLOW_LAST = 7'h4F;
  // strobe timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int SETUP_NS = 16;
  localparam int PULSE_NS = 96;
  localparam int HOLD_NS = 32;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TCNT_W = 4;
  // host apb map
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_RESULT = 8'h04;
  localparam logic [7:0] OFS_PINS = 8'h08;
  localparam int CMD_OP_LSB = 16;
  localparam int RES_BUSY = 16;
  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_WRITE_CFG = 2'h1;
  localparam logic [1:0] OP_READ_CFG = 2'h2;
  localparam logic [1:0] OP_READ_FLAGS = 2'h3;
  typedef enum {ALCS_IDLE, ALCS_SETUP, ALCS_PULSE, ALCS_HOLD} alcs_state_t;
endpackage

// ==== inc/alcs_bus_if.sv ====
/*
  parallel bus between host and device: data lines, strobes, flag pins.
  assumes neither end drives the data lines while the other does.
*/
`timescale 1ns/1ps
interface alcs_bus_if;
  logic [15:0] h2d_data;
  logic h2d_oe;
  logic [15:0] d2h_data;
  logic d2h_oe;
  logic [15:0] parallel_data_lines;
  logic config_word_strobe_n;
  logic register_read_strobe_n;
  logic half_select;
  logic rx_one_ready_pin_n;
  logic rx_one_half_pin_n;
  logic rx_one_full_pin_n;
  logic rx_two_ready_pin_n;
  logic rx_two_half_pin_n;
  logic rx_two_full_pin_n;
  logic tx_full_pin_n;
  logic tx_half_pin_n;
  // resolved level of the shared lines, undriven reads low
  assign parallel_data_lines = h2d_oe ? h2d_data : (d2h_oe ? d2h_data : 16'h0000);
  modport dev (
    input parallel_data_lines, config_word_strobe_n, register_read_strobe_n, half_select,
    output d2h_data, d2h_oe, rx_one_ready_pin_n, rx_one_half_pin_n, rx_one_full_pin_n,
    output rx_two_ready_pin_n, rx_two_half_pin_n, rx_two_full_pin_n, tx_full_pin_n,
    output tx_half_pin_n
  );
  modport host (
    input parallel_data_lines, rx_one_ready_pin_n, rx_one_half_pin_n, rx_one_full_pin_n,
    input rx_two_ready_pin_n, rx_two_half_pin_n, rx_two_full_pin_n, tx_full_pin_n,
    input tx_half_pin_n,
    output h2d_data, h2d_oe, config_word_strobe_n, register_read_strobe_n, half_select
  );
endinterface

// ==== logic/alcs_host.sv ====
/*
  host end: apb slave with command, result and pin registers; runs strobe
  sequences on the parallel bus.
  assumes the device answers a read strobe within a few clocks of the fall.
*/
`timescale 1ns/1ps
module alcs_host (
  input wire logic clk,
  input wire logic rst,
  alcs_bus_if.host bus,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  ////////////////////////////////////////////////////////////////////////////
  // synchronisers for data lines and flag pins
  logic [15:0] data_s1_reg;
  logic [15:0] data_s2_reg;
  logic [7:0] pin_s1_reg;
  logic [7:0] pin_s2_reg;
  wire [7:0] pins = {bus.tx_half_pin_n, bus.tx_full_pin_n, bus.rx_two_full_pin_n,
    bus.rx_two_half_pin_n, bus.rx_two_ready_pin_n, bus.rx_one_full_pin_n,
    bus.rx_one_half_pin_n, bus.rx_one_ready_pin_n};

  always_ff @(posedge clk) begin
    if (rst) begin
      data_s1_reg <= 16'h0000;
      data_s2_reg <= 16'h0000;
      pin_s1_reg <= 8'hFF;
      pin_s2_reg <= 8'hFF;
    end else begin
      data_s1_reg <= bus.parallel_data_lines;
      data_s2_reg <= data_s1_reg;
      pin_s1_reg <= pins;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave
  alcs_pkg::alcs_state_t state_reg;
  logic [1:0] op_reg;
  logic [15:0] wdata_reg;
  logic [15:0] result_reg;
  logic [3:0] tcnt_reg;
  wire busy = state_reg != alcs_pkg::ALCS_IDLE;
  wire access = psel & penable & ~pready;
  wire wr_done = psel & penable & pready & pwrite;
  wire [1:0] cmd_op = pwdata[alcs_pkg::CMD_OP_LSB +: 2];
  wire start = wr_done & (paddr == alcs_pkg::OFS_CMD) & ~busy & (cmd_op != alcs_pkg::OP_NONE);
  wire [31:0] rd_mux = (paddr == alcs_pkg::OFS_CMD) ? {14'h0000, op_reg, wdata_reg} :
    (paddr == alcs_pkg::OFS_RESULT) ? {15'h0000, busy, result_reg} :
    (paddr == alcs_pkg::OFS_PINS) ? {24'h000000, pin_s2_reg} : 32'h00000000;

  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= access;
      prdata <= access ? rd_mux : 32'h00000000;
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strobe sequencer
  wire tdone = tcnt_reg == 4'h0;
  wire is_write = op_reg == alcs_pkg::OP_WRITE_CFG;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= alcs_pkg::ALCS_IDLE;
      op_reg <= alcs_pkg::OP_NONE;
      wdata_reg <= 16'h0000;
      result_reg <= 16'h0000;
      tcnt_reg <= 4'h0;
      bus.h2d_data <= 16'h0000;
      bus.h2d_oe <= 1'b0;
      bus.config_word_strobe_n <= 1'b1;
      bus.register_read_strobe_n <= 1'b1;
      bus.half_select <= 1'b0;
    end else begin
      tcnt_reg <= tdone ? 4'h0 : tcnt_reg - 4'h1;
      case (state_reg)
        alcs_pkg::ALCS_IDLE: begin
          if (start) begin
            op_reg <= cmd_op;
            wdata_reg <= pwdata[15:0];
            bus.h2d_data <= pwdata[15:0];
            bus.h2d_oe <= cmd_op == alcs_pkg::OP_WRITE_CFG;
            bus.half_select <= cmd_op != alcs_pkg::OP_READ_FLAGS;
            tcnt_reg <= 4'(alcs_pkg::SETUP_CYC - 1);
            state_reg <= alcs_pkg::ALCS_SETUP;
          end
        end
        alcs_pkg::ALCS_SETUP: begin
          if (tdone) begin
            bus.config_word_strobe_n <= ~is_write;
            bus.register_read_strobe_n <= is_write;
            tcnt_reg <= 4'(alcs_pkg::PULSE_CYC - 1);
            state_reg <= alcs_pkg::ALCS_PULSE;
          end
        end
        alcs_pkg::ALCS_PULSE: begin
          if (tdone) begin
            if (!is_write) begin
              result_reg <= data_s2_reg;
            end
            bus.config_word_strobe_n <= 1'b1;
            bus.register_read_strobe_n <= 1'b1;
            tcnt_reg <= 4'(alcs_pkg::HOLD_CYC - 1);
            state_reg <= alcs_pkg::ALCS_HOLD;
          end
        end
        alcs_pkg::ALCS_HOLD: begin
          if (tdone) begin
            bus.h2d_oe <= 1'b0;
            state_reg <= alcs_pkg::ALCS_IDLE;
          end
        end
        default: begin
          state_reg <= alcs_pkg::ALCS_IDLE;
        end
      endcase
    end
  end
endmodule // alcs_host

// ==== testbench/alcs_link_asserts.sv ====
/*
  checker on the parallel bus between host and device ends.
  assumes it sits beside the one interface joining the two design ends.
*/
`timescale 1ns/1ps
module alcs_link_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic h2d_oe,
  input wire logic [15:0] d2h_data,
  input wire logic d2h_oe,
  input wire logic [15:0] parallel_data_lines,
  input wire logic config_word_strobe_n,
  input wire logic register_read_strobe_n,
  input wire logic half_select,
  input wire logic rx_one_ready_pin_n,
  input wire logic rx_one_half_pin_n,
  input wire logic rx_one_full_pin_n,
  input wire logic rx_two_ready_pin_n,
  input wire logic rx_two_half_pin_n,
  input wire logic rx_two_full_pin_n,
  input wire logic tx_full_pin_n,
  input wire logic tx_half_pin_n
);
  logic [15:0] cfg_model_reg;
  wire flag_rd = d2h_oe && !half_select && !register_read_strobe_n;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // expected configuration word
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_model_reg <= alcs_pkg::CFG_RESET;
    end else if (!config_word_strobe_n) begin
      cfg_model_reg <= parallel_data_lines;
    end
  end
  ////////////////////////////////////////
  property p_strobe_len;
    $fell(config_word_strobe_n) |-> !config_word_strobe_n[*8] ##1 !config_word_strobe_n[*4]
      ##1 config_word_strobe_n;
  endproperty
  a_strobe_len: assert property (p_strobe_len)
    else $error("config strobe pulse length wrong");
  property p_strobe_data;
    !config_word_strobe_n |-> h2d_oe && half_select;
  endproperty
  a_strobe_data: assert property (p_strobe_data)
    else $error("config strobe without driven data");
  property p_cfg_readback;
    d2h_oe && half_select && !register_read_strobe_n |-> d2h_data == cfg_model_reg;
  endproperty
  a_cfg_readback: assert property (p_cfg_readback)
    else $error("config readback differs");
  property p_read_answer;
    $fell(register_read_strobe_n) |-> ##[1:4] d2h_oe;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("device did not drive on read");
  property p_no_clash;
    !(h2d_oe && d2h_oe);
  endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive the data lines");
  property p_flag_zero;
    flag_rd |-> d2h_data[15:9] == 7'h00;
  endproperty
  a_flag_zero: assert property (p_flag_zero)
    else $error("unused flag lines not zero");
  property p_flag_pins;
    flag_rd |-> {d2h_data[8:7], d2h_data[5:0]} == ~{tx_half_pin_n, tx_full_pin_n,
      rx_two_full_pin_n, rx_two_half_pin_n, rx_two_ready_pin_n, rx_one_full_pin_n,
      rx_one_half_pin_n, rx_one_ready_pin_n};
  endproperty
  a_flag_pins: assert property (p_flag_pins)
    else $error("flag word and pins disagree");
  property p_rx1_levels;
    !rx_one_full_pin_n |-> !rx_one_half_pin_n && !rx_one_ready_pin_n;
  endproperty
  a_rx1_levels: assert property (p_rx1_levels)
    else $error("receiver one pins inconsistent");
  property p_rx2_levels;
    !rx_two_full_pin_n |-> !rx_two_half_pin_n && !rx_two_ready_pin_n;
  endproperty
  a_rx2_levels: assert property (p_rx2_levels)
    else $error("receiver two pins inconsistent");
  property p_tx_levels;
    !tx_full_pin_n |-> !tx_half_pin_n;
  endproperty
  a_tx_levels: assert property (p_tx_levels)
    else $error("transmit pins inconsistent");
endmodule // alcs_link_asserts

// ==== testbench/alcs_test.sv ====
/*
  bench: host and device joined by the bus interface, apb tasks drive the
  host, device side inputs driven directly.
  assumes package, interface and design ends compiled first.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("[FAIL] %0t: got %0h expected %0h", $time, (g), (e)); \
  end \
end
module alcs_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic [5:0] rx_one_count = 6'h00;
  logic [5:0] rx_two_count = 6'h00;
  logic [5:0] tx_count = 6'h00;
  logic tx_load_pulse = 1'b0;
  logic [1:0] rx_read_pulse = 2'h0;
  logic [30:0] tx_word_low = 31'h00000000;
  logic tx_data_bit32 = 1'b0;
  logic tx_serial = 1'b0;
  logic [1:0] rx_line_in = 2'h0;
  logic [1:0] rx_word_done = 2'h0;
  logic [1:0] rx_bit9 = 2'h0;
  logic [1:0] rx_bit10 = 2'h0;
  logic [1:0] rx_label_hit = 2'h0;
  logic tx_label_write, tx_fifo_write, tx_bit32_out, word_bit_order;
  logic [1:0] rx_label_read, rx_fifo_read, rx_logic_in, rx_fifo_load;
  logic [2:0] rate_tick;
  logic [15:0] config_word;
  int num_errors = 0;
  int samples_checked = 0;
  always #4 clk = ~clk;
  ////////////////////////////////////////
  alcs_bus_if bus ();
  alcs_device i_alcs_device (.clk, .rst, .bus(bus), .rx_one_count, .rx_two_count, .tx_count,
    .tx_load_pulse, .rx_read_pulse, .tx_word_low, .tx_data_bit32, .tx_serial, .rx_line_in,
    .rx_word_done, .rx_bit9, .rx_bit10, .rx_label_hit, .tx_label_write, .tx_fifo_write,
    .rx_label_read, .rx_fifo_read, .rate_tick, .tx_bit32_out, .rx_logic_in, .rx_fifo_load,
    .config_word, .word_bit_order);
  alcs_host i_alcs_host (.clk, .rst, .bus(bus), .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr);
  alcs_link_asserts i_alcs_link_asserts (.clk, .rst, .h2d_oe(bus.h2d_oe),
    .d2h_data(bus.d2h_data), .d2h_oe(bus.d2h_oe),
    .parallel_data_lines(bus.parallel_data_lines),
    .config_word_strobe_n(bus.config_word_strobe_n),
    .register_read_strobe_n(bus.register_read_strobe_n), .half_select(bus.half_select),
    .rx_one_ready_pin_n(bus.rx_one_ready_pin_n), .rx_one_half_pin_n(bus.rx_one_half_pin_n),
    .rx_one_full_pin_n(bus.rx_one_full_pin_n), .rx_two_ready_pin_n(bus.rx_two_ready_pin_n),
    .rx_two_half_pin_n(bus.rx_two_half_pin_n), .rx_two_full_pin_n(bus.rx_two_full_pin_n),
    .tx_full_pin_n(bus.tx_full_pin_n), .tx_half_pin_n(bus.tx_half_pin_n));
  ////////////////////////////////////////
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      num_errors++;
      $display("[FAIL] %0t: no pready", $time);
      results();
    end
    `CHK(pslverr, 1'b0)
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic op(input logic [1:0] code, input logic [15:0] d, output logic [15:0] res);
    logic [31:0] r;
    int n;
    n = 0;
    apb(1'b1, alcs_pkg::OFS_CMD, {14'h0000, code, d}, r);
    do begin
      apb(1'b0, alcs_pkg::OFS_RESULT, 32'h00000000, r);
      n++;
    end while (r[alcs_pkg::RES_BUSY] !== 1'b0 && n < 40);
    if (r[alcs_pkg::RES_BUSY] !== 1'b0) begin
      num_errors++;
      $display("[FAIL] %0t: host stays busy", $time);
      results();
    end
    res = r[15:0];
  endtask
  task automatic strike(input logic [1:0] d, input logic l, input logic [1:0] r);
    rx_word_done <= d;
    tx_load_pulse <= l;
    rx_read_pulse <= r;
    @(posedge clk);
    rx_word_done <= 2'h0;
    tx_load_pulse <= 1'b0;
    rx_read_pulse <= 2'h0;
    @(posedge clk);
  endtask
  task automatic rate(input int k, input int exp);
    int n;
    for (int j = 0; j < 3; j++) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (rate_tick[k] !== 1'b1 && n < 300);
    end
    `CHK(n, exp)
  endtask
  function automatic logic [8:0] flags(input logic [5:0] a, input logic [5:0] b,
                                       input logic [5:0] t);
    return {t >= 6'h10, t >= 6'h20, t == 6'h00, b >= 6'h20, b >= 6'h10, b != 6'h00,
            a >= 6'h20, a >= 6'h10, a != 6'h00};
  endfunction
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin : main
    logic [15:0] res, cfg;
    logic [31:0] rd;
    logic [30:0] w;
    logic [8:0] fl;
    logic [5:0] lv [6] = '{6'h00, 6'h01, 6'h0F, 6'h10, 6'h1F, 6'h20};
    logic [15:0] pat [4] = '{16'hA5C3, 16'h5A3C, 16'hFFFF, 16'h0000};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK(config_word, alcs_pkg::CFG_RESET)
    apb(1'b0, 8'h0C, 32'h00000000, rd);
    `CHK(rd, 32'h00000000)
    foreach (pat[i]) begin
      op(alcs_pkg::OP_WRITE_CFG, pat[i], res);
      `CHK(config_word, pat[i])
      `CHK(word_bit_order, pat[i][15])
      op(alcs_pkg::OP_READ_CFG, 16'h0000, res);
      `CHK(res, pat[i])
    end
    for (int i = 0; i < 6; i++) begin
      rx_one_count <= lv[i];
      rx_two_count <= lv[5 - i];
      tx_count <= lv[(i + 2) % 6];
      repeat (4) @(posedge clk);
      fl = flags(lv[i], lv[5 - i], lv[(i + 2) % 6]);
      op(alcs_pkg::OP_READ_FLAGS, 16'h0000, res);
      `CHK(res, {7'h00, fl})
      apb(1'b0, alcs_pkg::OFS_PINS, 32'h00000000, rd);
      `CHK(rd[7:0], ~{fl[8:7], fl[5:0]})
    end
    for (int i = 0; i < 4; i++) begin
      cfg = (i[0] ? 16'h0011 : 16'h4000) | (i[1] ? 16'h3000 : 16'h0000);
      cfg = cfg | ((i[0] ^ i[1]) ? 16'h0020 : 16'h0000);
      w = 31'h2AAA5555 ^ 31'(i);
      tx_word_low <= w;
      tx_data_bit32 <= i[1];
      tx_serial <= ~i[0];
      rx_line_in <= 2'(i);
      op(alcs_pkg::OP_WRITE_CFG, cfg, res);
      `CHK(tx_bit32_out, cfg[4] ? (cfg[12] ? ^w : ~^w) : i[1])
      `CHK(rx_logic_in, cfg[5] ? 2'(i) : {2{~i[0]}})
      rate(0, cfg[0] ? 80 : 10);
      rate(1, cfg[14] ? 80 : 10);
      rate(2, cfg[13] ? 80 : 10);
    end
    for (int i = 0; i < 16; i++) begin
      cfg = 16'h0920 | (i[0] ? 16'h000C : 16'h0000) | (i[2] ? 16'h0240 : 16'h0000);
      op(alcs_pkg::OP_WRITE_CFG, cfg, res);
      rx_label_hit <= {2{i[1]}};
      rx_bit9 <= {2{~i[3]}};
      rx_bit10 <= 2'h3;
      strike(2'h3, 1'b0, 2'h0);
      `CHK(rx_fifo_load, {2{(!i[0] || i[1]) && (!i[2] || i[3])}})
    end
    for (int m = 0; m < 2; m++) begin
      op(alcs_pkg::OP_WRITE_CFG, m[0] ? 16'h0022 : 16'h0020, res);
      strike(2'h0, 1'b1, m[0] ? 2'h2 : 2'h1);
      `CHK(tx_label_write, m[0])
      `CHK(tx_fifo_write, ~m[0])
      `CHK(rx_label_read, m[0] ? 2'h2 : 2'h0)
      `CHK(rx_fifo_read, m[0] ? 2'h0 : 2'h1)
    end
    results();
  end
  initial begin : watchdog
    repeat (30000) @(posedge clk);
    num_errors++;
    results();
  end
endmodule // alcs_test
